/* verilog/uart_control_and_baud_gen.sv */
`timescale 1ns/10ps
`include "uart_ctrl_map.svh"
module uart_control_and_baud_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port_clock_on,
    input wire logic tx_serial,
    input wire logic tx_busy,
    input wire logic rx_word_valid,
    input wire logic [8:0] rx_word,
    output logic tx_start,
    output logic [8:0] tx_word,
    output logic tx_active,
    output logic rx_active,
    output logic rx_serial,
    output logic nine_bit_mode,
    output logic baud_tick,
    output logic transmit_pin_o,
    output logic transmit_pin_oe_n,
    input wire logic shared_pin_i,
    output logic shared_pin_o,
    output logic shared_pin_oe_n,
    output logic irq_request,
    output logic wake_request
);
    // ======================================================
    // state
    uart_ctrl_pkg::reg_byte_t ctrl_one_q, ctrl_two_q, baud_q, tx_hold_q, rx_data_q;
    logic single_wire_q, rx_ninth_q, hold_full_q;
    logic overrun_q, rx_avail_q, tx_idle_q, tx_empty_q;
    logic shared_prev_q;
    logic [7:0] div_cnt_q;
    logic [5:0] pre_cnt_q;
    uart_ctrl_pkg::tx_state_t tx_state_q, tx_state_d;

    // count down with wrap; used by both baud counters
    function automatic logic [7:0] wrap_dec(input logic [7:0] v, input logic [7:0] top);
        wrap_dec = (v == 8'h00) ? top : v - 8'h01;
    endfunction

    // ======================================================
    // control decode
    wire port_en = ctrl_one_q[`B1_PORT_EN];
    wire word9 = ctrl_one_q[`B1_WORD_LEN];
    wire brk = ctrl_one_q[`B1_BREAK];
    wire tx_en = ctrl_two_q[`B2_TX_EN];
    wire rx_en = ctrl_two_q[`B2_RX_EN];
    wire speed_hi = ctrl_two_q[`B2_SPEED];
    wire addr_en = ctrl_two_q[`B2_ADDR_EN];
    wire wake_en = ctrl_two_q[`B2_WAKE_EN];
    wire tx_on = port_en & tx_en;
    wire rx_on = port_en & rx_en;
    // single wire transmits on the shared pin only when the receiver is off
    wire sw_tx = single_wire_q & tx_on & ~rx_en;
    wire tx_pin_drive = tx_on & ~single_wire_q;

    // ======================================================
    // apb decode; one setup cycle, then access phase completes at once
    wire setup = psel & ~penable;
    wire wr = psel & penable & pready & pwrite;
    wire rd = psel & penable & pready & ~pwrite;
    wire hit_one = (paddr == `OFS_CTRL_ONE);
    wire hit_two = (paddr == `OFS_CTRL_TWO);
    wire hit_sw = (paddr == `OFS_SWIRE);
    wire hit_data = (paddr == `OFS_DATA);
    wire hit_baud = (paddr == `OFS_BAUD);
    wire hit_stat = (paddr == `OFS_STATUS);
    wire hit_any = hit_one | hit_two | hit_sw | hit_data | hit_baud | hit_stat;
    wire [7:0] stat_byte = {3'h0, wake_request, overrun_q, rx_avail_q, tx_idle_q, tx_empty_q};
    // transmit-only ninth bit reads zero; received ninth bit read in its place
    wire [7:0] one_rd = {ctrl_one_q[7:2], rx_ninth_q, 1'b0};
    wire [7:0] rd_byte;
    assign rd_byte = hit_one ? one_rd :
                     hit_two ? ctrl_two_q :
                     hit_sw ? {7'h00, single_wire_q} :
                     hit_data ? rx_data_q :
                     hit_baud ? baud_q :
                     hit_stat ? stat_byte : 8'h00;
    // a full holding register refuses the write rather than lose the older byte
    wire data_wr = wr & hit_data & ~hold_full_q;
    wire data_rd = rd & hit_data;

    // ======================================================
    // apb answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (clk_en) begin
            pready <= setup;
            pslverr <= setup & ~hit_any;
            prdata <= setup ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // ======================================================
    // control registers; master disable clears transmit and receive enables and break only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_one_q <= `RST_CTRL;
            ctrl_two_q <= `RST_CTRL;
            single_wire_q <= 1'b0;
            baud_q <= `RST_BAUD;
        end else if (clk_en) begin
            if (wr & hit_one) ctrl_one_q <= pwdata[7:0];
            else if (!port_en) ctrl_one_q[`B1_BREAK] <= 1'b0;
            if (wr & hit_two) ctrl_two_q <= pwdata[7:0];
            else if (!port_en) ctrl_two_q[7:6] <= 2'b00;
            if (wr & hit_sw) single_wire_q <= pwdata[0];
            if (wr & hit_baud) baud_q <= pwdata[7:0];
        end
    end

    // ======================================================
    // baud generator: prescaler of 64 or 16, then divide by N+1
    wire [7:0] pre_top = speed_hi ? {2'b00, `PRE_TOP_HIGH} : {2'b00, `PRE_TOP_LOW};
    wire pre_wrap = ({2'b00, pre_cnt_q} == 8'h00);
    wire tick_now = pre_wrap & (div_cnt_q == 8'h00);
    // next prescaler count at the function width; only its low six bits are stored
    wire [7:0] pre_next = wrap_dec({2'b00, pre_cnt_q}, pre_top);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_q <= 6'h00;
            div_cnt_q <= 8'h00;
            baud_tick <= 1'b0;
        end else if (clk_en) begin
            if (!port_en) begin
                pre_cnt_q <= pre_top[5:0];
                div_cnt_q <= baud_q;
                baud_tick <= 1'b0;
            end else begin
                // one tick feeds both directions
                pre_cnt_q <= pre_next[5:0];
                if (pre_wrap) div_cnt_q <= wrap_dec(div_cnt_q, baud_q);
                baud_tick <= tick_now;
            end
        end
    end

    // ======================================================
    // transmit path state
    always_comb begin
        tx_state_d = tx_state_q;
        case (tx_state_q)
            uart_ctrl_pkg::TX_IDLE: begin
                if (brk) tx_state_d = uart_ctrl_pkg::TX_BREAK;
                else if (tx_start | tx_busy) tx_state_d = uart_ctrl_pkg::TX_SHIFT;
            end
            uart_ctrl_pkg::TX_SHIFT: begin
                if (!tx_busy & !tx_start & !hold_full_q) begin
                    tx_state_d = brk ? uart_ctrl_pkg::TX_BREAK : uart_ctrl_pkg::TX_IDLE;
                end
            end
            uart_ctrl_pkg::TX_BREAK: begin
                if (!brk) tx_state_d = uart_ctrl_pkg::TX_IDLE;
            end
            default: tx_state_d = uart_ctrl_pkg::TX_IDLE;
        endcase
        if (!tx_on) tx_state_d = uart_ctrl_pkg::TX_IDLE;
    end

    // holding register handed to the shifter when it is free
    wire hand_over = hold_full_q & ~tx_busy & ~tx_start & tx_on &
                     (tx_state_q != uart_ctrl_pkg::TX_BREAK);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_q <= uart_ctrl_pkg::TX_IDLE;
            tx_hold_q <= `RST_DATA;
            hold_full_q <= 1'b0;
            tx_start <= 1'b0;
            tx_word <= 9'h000;
        end else if (clk_en) begin
            tx_state_q <= tx_state_d;
            tx_start <= hand_over;
            if (hand_over) tx_word <= {ctrl_one_q[`B1_TX_NINTH] & word9, tx_hold_q};
            if (data_wr) tx_hold_q <= pwdata[7:0];
            if (!tx_on) hold_full_q <= 1'b0;
            else if (data_wr) hold_full_q <= 1'b1;
            else if (hand_over) hold_full_q <= 1'b0;
        end
    end

    // ======================================================
    // receive path and flags; a new word beats a clearing read
    wire addr_bit = word9 ? rx_word[8] : rx_word[7];
    wire rx_keep = rx_word_valid & rx_on & (~addr_en | addr_bit);
    wire idle_now = ~hold_full_q & ~tx_busy & ~tx_start & ~hand_over;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_q <= `RST_DATA;
            rx_ninth_q <= 1'b0;
            rx_avail_q <= 1'b0;
            overrun_q <= 1'b0;
            tx_idle_q <= 1'b1;
            tx_empty_q <= 1'b1;
        end else if (clk_en) begin
            // a word that lands with the clearing read replaces the byte just read
            if (rx_keep & (~rx_avail_q | data_rd)) begin
                rx_data_q <= rx_word[7:0];
                rx_ninth_q <= rx_word[8] & word9;
            end
            if (!rx_on) begin
                rx_avail_q <= 1'b0;
                overrun_q <= 1'b0;
            end else begin
                if (rx_keep) rx_avail_q <= 1'b1;
                else if (data_rd) rx_avail_q <= 1'b0;
                // word lost while the previous one is still unread
                if (rx_keep & rx_avail_q & ~data_rd) overrun_q <= 1'b1;
                else if (data_rd) overrun_q <= 1'b0;
            end
            tx_empty_q <= ~hold_full_q | ~tx_on;
            tx_idle_q <= idle_now | ~tx_on;
        end
    end

    // ======================================================
    // pins, enables to the shifter, interrupt request
    wire [2:0] irq_src = {ctrl_two_q[`B2_RIE] & (overrun_q | rx_avail_q),
                          ctrl_two_q[`B2_TIIE] & tx_idle_q,
                          ctrl_two_q[`B2_TEIE] & tx_empty_q};
    wire line_out = (tx_state_q == uart_ctrl_pkg::TX_BREAK) ? 1'b0 : tx_serial;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transmit_pin_o <= 1'b1;
            transmit_pin_oe_n <= 1'b1;
            shared_pin_o <= 1'b1;
            shared_pin_oe_n <= 1'b1;
            rx_serial <= 1'b1;
            tx_active <= 1'b0;
            rx_active <= 1'b0;
            nine_bit_mode <= 1'b0;
            irq_request <= 1'b0;
        end else if (clk_en) begin
            transmit_pin_o <= line_out;
            transmit_pin_oe_n <= ~tx_pin_drive;
            shared_pin_o <= line_out;
            shared_pin_oe_n <= ~sw_tx;
            rx_serial <= rx_on ? shared_pin_i : 1'b1;
            tx_active <= tx_on;
            rx_active <= rx_on;
            nine_bit_mode <= word9;
            irq_request <= |irq_src;
        end
    end

    // ======================================================
    // pin wake: only while the port clock is stopped
    wire pin_fall = shared_prev_q & ~shared_pin_i;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_prev_q <= 1'b1;
            wake_request <= 1'b0;
        end else if (clk_en) begin
            shared_prev_q <= shared_pin_i;
            // set wins over a clearing write; software then restarts the clock
            if (wake_en & ~port_clock_on & pin_fall) wake_request <= 1'b1;
            else if (wr & hit_stat & pwdata[`BS_WAKE]) wake_request <= 1'b0;
        end
    end

    // ======================================================
    // checks
    // two ticks after a divisor or speed change: the first period may still be old
    logic [15:0] gap_q;
    logic [1:0] seen_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 16'h0000;
            seen_q <= 2'h0;
        end else if (clk_en) begin
            gap_q <= baud_tick ? 16'h0001 : gap_q + 16'h0001;
            if (!port_en | (wr & (hit_baud | hit_two))) seen_q <= 2'h0;
            else if (baud_tick & (seen_q != 2'h2)) seen_q <= seen_q + 2'h1;
        end
    end

    baud_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en & baud_tick & (seen_q == 2'h2) |->
        gap_q == (speed_hi ? 16'd16 : 16'd64) * ({8'h00, baud_q} + 16'd1))
        else $error("baud tick spacing wrong");
    tx_float_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en & ~tx_on |=> transmit_pin_oe_n & ~tx_start & tx_empty_q)
        else $error("transmit pin not released");
    rx_float_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en & ~rx_on |=> ~rx_active & ~rx_avail_q & rx_serial)
        else $error("receiver not reset");
    addr_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en & rx_word_valid & rx_on & addr_en & addr_bit |=> rx_avail_q)
        else $error("address word lost");
    addr_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en & rx_word_valid & addr_en & ~addr_bit & ~rx_avail_q |=> ~rx_avail_q)
        else $error("data word not dropped");
    wake_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en & (port_clock_on | ~wake_en) |=> ~$rose(wake_request))
        else $error("wake while clock runs");
    irq_rx_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en & ctrl_two_q[`B2_RIE] & rx_avail_q |=> irq_request)
        else $error("receive irq missing");
    irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en & (ctrl_two_q[2:0] == 3'b000) |=> ~irq_request)
        else $error("masked irq raised");
    master_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en & ~port_en & ~wr ##1 clk_en |=> ~tx_en & tx_idle_q & tx_empty_q)
        else $error("master disable incomplete");
    swire_both_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en & single_wire_q & tx_en & rx_en |=> shared_pin_oe_n)
        else $error("shared pin driven with both on");
    swire_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en & setup & hit_sw |=> prdata[31:1] == 31'h00000000)
        else $error("upper bits not zero");
endmodule // uart_control_and_baud_gen

/* verilog/uart_ctrl_map.svh */
`ifndef UART_CTRL_MAP_SVH
`define UART_CTRL_MAP_SVH
// ==========================================================
// register byte offsets
`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_TWO 8'h04
`define OFS_SWIRE 8'h08
`define OFS_DATA 8'h0c
`define OFS_BAUD 8'h10
`define OFS_STATUS 8'h14
// ==========================================================
// ctrl_one fields
`define B1_PORT_EN 7
`define B1_WORD_LEN 6
`define B1_BREAK 2
`define B1_RX_NINTH 1
`define B1_TX_NINTH 0
// uart_ctrl_two fields
`define B2_TX_EN 7
`define B2_RX_EN 6
`define B2_SPEED 5
`define B2_ADDR_EN 4
`define B2_WAKE_EN 3
`define B2_RIE 2
`define B2_TIIE 1
`define B2_TEIE 0
// status fields
`define BS_WAKE 4
`define BS_OVERRUN 3
`define BS_RX_AVAIL 2
`define BS_TX_IDLE 1
`define BS_TX_EMPTY 0
// ==========================================================
// reset values and baud factors
`define RST_CTRL 8'h00
`define RST_DATA 8'h00
`define RST_BAUD 8'h00
`define PRE_TOP_LOW 6'h3f
`define PRE_TOP_HIGH 6'h0f
`endif

/* verilog/uart_ctrl_pkg.sv */
package uart_ctrl_pkg;
    // transmit path state, one-hot
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SHIFT = 3'b010,
        TX_BREAK = 3'b100
    } tx_state_t;
    typedef logic [7:0] reg_byte_t;
endpackage

/* testbench/serial_far_node.sv */
`timescale 1ns/10ps
// ==========================================================
// far side model: outside shifter and remote node words
module serial_far_node (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_start,
    output logic tx_busy,
    output logic tx_serial,
    output logic rx_word_valid,
    output logic [8:0] rx_word
);
    parameter int BUSY_CYCLES = 20;
    int busy_cnt;
    initial begin
        rx_word_valid = 1'b0;
        rx_word = 9'h000;
    end
    // busy rises the cycle after a start, line toggles while shifting
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt <= 0;
            tx_busy <= 1'b0;
            tx_serial <= 1'b1;
        end else if (tx_start) begin
            busy_cnt <= BUSY_CYCLES;
            tx_busy <= 1'b1;
            tx_serial <= 1'b0;
        end else if (busy_cnt > 1) begin
            busy_cnt <= busy_cnt - 1;
            tx_serial <= ~tx_serial;
        end else begin
            busy_cnt <= 0;
            tx_busy <= 1'b0;
            tx_serial <= 1'b1;
        end
    end
    // one received word; afterwards the bus shows the inverse, never a stale copy
    task automatic push_word(input logic [8:0] w);
        @(posedge pclk);
        rx_word_valid <= 1'b1;
        rx_word <= w;
        @(posedge pclk);
        rx_word_valid <= 1'b0;
        rx_word <= ~w;
    endtask
endmodule // serial_far_node

/* testbench/tb_uart_control_and_baud_gen.sv */
`timescale 1ns/10ps
`include "uart_ctrl_map.svh"
module tb_uart_control_and_baud_gen;
    // ==========================================================
    // signals
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, tx_serial, tx_busy, rx_word_valid, tx_start, tx_active;
    logic rx_active, rx_serial, nine_bit_mode, baud_tick, transmit_pin_o, transmit_pin_oe_n;
    logic shared_pin_o, shared_pin_oe_n, irq_request, wake_request, shared_line;
    logic port_clock_on = 1'b1, line_drv = 1'b1, clk_en = 1'b1;
    logic [8:0] rx_word, tx_word;
    int err_total = 0, samples_checked = 0;
    always #20 pclk = ~pclk;
    // the wire follows the block only while it drives, else the remote node
    assign shared_line = (shared_pin_oe_n === 1'b0) ? shared_pin_o : line_drv;
    uart_control_and_baud_gen DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_clock_on(port_clock_on),
        .tx_serial(tx_serial), .tx_busy(tx_busy), .rx_word_valid(rx_word_valid),
        .rx_word(rx_word), .tx_start(tx_start), .tx_word(tx_word), .tx_active(tx_active),
        .rx_active(rx_active), .rx_serial(rx_serial), .nine_bit_mode(nine_bit_mode),
        .baud_tick(baud_tick), .transmit_pin_o(transmit_pin_o),
        .transmit_pin_oe_n(transmit_pin_oe_n), .shared_pin_i(shared_line),
        .shared_pin_o(shared_pin_o), .shared_pin_oe_n(shared_pin_oe_n),
        .irq_request(irq_request), .wake_request(wake_request));
    serial_far_node far (.pclk(pclk), .presetn(presetn), .tx_start(tx_start),
        .tx_busy(tx_busy), .tx_serial(tx_serial), .rx_word_valid(rx_word_valid),
        .rx_word(rx_word));
    // ==========================================================
    // checking and bus tasks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic timed_out();
        chk(32'h0, 32'h1);
        give_verdict();
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // request held until pready is sampled high; no latency assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) timed_out();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
        input logic [31:0] m = 32'hffffffff);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, exp);
    endtask
    task automatic tick_gap(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (baud_tick !== 1'b1 && n < 20000);
        if (n >= 20000) timed_out();
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd(`OFS_CTRL_TWO, 32'h00);
        rd(`OFS_SWIRE, 32'h00);
        rd(`OFS_STATUS, 32'h03);
        wr(`OFS_SWIRE, 32'hff);
        rd(`OFS_SWIRE, 32'h01);
        wr(`OFS_SWIRE, 32'h00);
        wr(`OFS_BAUD, 32'h37);
        rd(`OFS_BAUD, 32'h37);
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk(e, 32'h1);
        chk(r, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_baud();
        int nv[3] = '{2, 255, 0};
        int sv[3] = '{1, 0, 1};
        int n;
        wr(`OFS_CTRL_ONE, 32'h80);
        for (int i = 0; i < 3; i++) begin
            wr(`OFS_BAUD, nv[i]);
            wr(`OFS_CTRL_TWO, sv[i] << 5);
            tick_gap(n);
            tick_gap(n);
            tick_gap(n);
            chk(n, (sv[i] ? 16 : 64) * (nv[i] + 1));
        end
        $display("test baud done");
    endtask
    task automatic t_tx();
        int n;
        wr(`OFS_CTRL_ONE, 32'hc1);
        wr(`OFS_CTRL_TWO, 32'h80);
        idle(2);
        chk(nine_bit_mode, 32'h1);
        chk(transmit_pin_oe_n, 32'h0);
        wr(`OFS_DATA, 32'h33);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (tx_start !== 1'b1 && n < 20);
        if (n >= 20) timed_out();
        chk(tx_word, 32'h133);
        // break holds the line low once the shifter has finished
        wr(`OFS_CTRL_ONE, 32'hc5);
        idle(30);
        chk(transmit_pin_o, 32'h0);
        chk(shared_pin_o, 32'h0);
        wr(`OFS_CTRL_ONE, 32'hc1);
        idle(3);
        chk(transmit_pin_o, 32'h1);
        wr(`OFS_CTRL_TWO, 32'h00);
        idle(2);
        chk(transmit_pin_oe_n, 32'h1);
        chk(tx_active, 32'h0);
        rd(`OFS_STATUS, 32'h1, 32'h1);
        wr(`OFS_CTRL_ONE, 32'h80);
        idle(30);
        $display("test tx done");
    endtask
    task automatic t_rx();
        wr(`OFS_CTRL_TWO, 32'h54);
        far.push_word(9'h012);
        idle(3);
        chk(irq_request, 32'h0);
        rd(`OFS_STATUS, 32'h0, 32'h4);
        far.push_word(9'h0a5);
        idle(3);
        chk(irq_request, 32'h1);
        rd(`OFS_DATA, 32'ha5);
        idle(2);
        chk(irq_request, 32'h0);
        far.push_word(9'h081);
        far.push_word(9'h082);
        idle(3);
        rd(`OFS_STATUS, 32'h0c, 32'h0c);
        wr(`OFS_CTRL_TWO, 32'h50);
        idle(2);
        chk(irq_request, 32'h0);
        rd(`OFS_DATA, 32'h81, 32'hff);
        $display("test rx done");
    endtask
    task automatic t_irq();
        logic [7:0] en[3] = '{8'h02, 8'h01, 8'h00};
        logic [31:0] ex[3] = '{32'h1, 32'h1, 32'h0};
        for (int i = 0; i < 3; i++) begin
            wr(`OFS_CTRL_TWO, en[i]);
            idle(2);
            chk(irq_request, ex[i]);
        end
        $display("test irq done");
    endtask
    task automatic fall_edge(input logic exp);
        line_drv <= 1'b1;
        idle(3);
        line_drv <= 1'b0;
        idle(4);
        chk(wake_request, exp);
    endtask
    task automatic t_wake();
        wr(`OFS_CTRL_TWO, 32'h48);
        port_clock_on <= 1'b0;
        fall_edge(1'b1);
        chk(rx_serial, 32'h0);
        port_clock_on <= 1'b1;
        wr(`OFS_STATUS, 32'h10);
        idle(2);
        chk(wake_request, 32'h0);
        fall_edge(1'b0);
        wr(`OFS_CTRL_TWO, 32'h40);
        port_clock_on <= 1'b0;
        fall_edge(1'b0);
        port_clock_on <= 1'b1;
        line_drv <= 1'b1;
        $display("test wake done");
    endtask
    task automatic t_swire();
        logic [7:0] sw[3] = '{8'h01, 8'h01, 8'h00};
        logic [7:0] c2[3] = '{8'h80, 8'hc0, 8'h80};
        logic [31:0] ex[3] = '{32'h0, 32'h1, 32'h1};
        for (int i = 0; i < 3; i++) begin
            wr(`OFS_SWIRE, sw[i]);
            wr(`OFS_CTRL_TWO, c2[i]);
            idle(2);
            chk(shared_pin_oe_n, ex[i]);
        end
        $display("test swire done");
    endtask
    // clock enable low: a pin edge must not be seen until the block runs again
    task automatic t_freeze();
        wr(`OFS_CTRL_TWO, 32'h08);
        port_clock_on <= 1'b0;
        line_drv <= 1'b1;
        idle(3);
        clk_en <= 1'b0;
        line_drv <= 1'b0;
        idle(4);
        chk(wake_request, 32'h0);
        clk_en <= 1'b1;
        idle(3);
        chk(wake_request, 32'h1);
        port_clock_on <= 1'b1;
        wr(`OFS_STATUS, 32'h10);
        idle(2);
        chk(wake_request, 32'h0);
        line_drv <= 1'b1;
        $display("test freeze done");
    endtask
    task automatic t_disable();
        wr(`OFS_CTRL_TWO, 32'hc4);
        far.push_word(9'h0a5);
        idle(3);
        wr(`OFS_CTRL_ONE, 32'h00);
        idle(2);
        rd(`OFS_CTRL_TWO, 32'h04);
        rd(`OFS_STATUS, 32'h03, 32'h0f);
        chk(rx_active, 32'h0);
        chk(transmit_pin_oe_n, 32'h1);
        chk(shared_pin_oe_n, 32'h1);
        $display("test disable done");
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_baud();
        t_tx();
        t_rx();
        t_irq();
        t_wake();
        t_swire();
        t_disable();
        t_freeze();
        give_verdict();
    end
endmodule // tb_uart_control_and_baud_gen
